// *** src/accel_cfg_pkg.sv ***
// package: register indices, field positions, reset values and carriers
package accel_cfg_pkg;

    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_BUF_Y_LOW = 8'h0E;
    localparam logic [7:0] IDX_BUF_Y_HIGH = 8'h0F;
    localparam logic [7:0] IDX_BUF_Z_LOW = 8'h10;
    localparam logic [7:0] IDX_BUF_Z_HIGH = 8'h11;
    localparam logic [7:0] IDX_PRODUCT_REVISION = 8'h12;
    localparam logic [7:0] IDX_DEVICE_IDENTITY = 8'h13;
    localparam logic [7:0] IDX_OPERATING_STATE = 8'h14;
    localparam logic [7:0] IDX_RANGE_SELFTEST = 8'h15;
    localparam logic [7:0] IDX_POWER_BYTEORDER = 8'h16;
    localparam logic [7:0] IDX_RATE_DECIMATION = 8'h17;
    localparam logic [7:0] IDX_WAKE_IRQ_PIN = 8'h18;
    localparam logic [7:0] IDX_AXIS_SKIP = 8'h19;
    localparam logic [7:0] IDX_WAKE_IDLE_LOW = 8'h1A;
    localparam logic [7:0] IDX_WAKE_IDLE_HIGH = 8'h1B;
    localparam logic [7:0] IDX_SLEEP_IDLE_LOW = 8'h1C;
    localparam logic [7:0] IDX_SLEEP_IDLE_HIGH = 8'h1D;
    localparam logic [7:0] IDX_INACT_LOW = 8'h1E;
    localparam logic [7:0] IDX_INACT_HIGH = 8'h1F;
    localparam logic [7:0] IDX_STREAM_PTR = 8'h30;
    localparam logic [7:0] IDX_STREAM_DATA = 8'h31;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h32;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h33;

    // ==========================================================
    // field positions
    localparam int BIT_SOFT_RESET = 7;      // range_selftest_control
    localparam int BIT_BYTE_ORDER = 2;      // power_byteorder_control
    localparam int BIT_X_SKIP = 7;          // axis_skip_hibernate_control
    localparam int BIT_Y_SKIP = 6;
    localparam int BIT_Z_SKIP = 5;
    localparam int EV_GATE_ERROR = 0;       // interrupt status bits
    localparam int EV_SOFT_RESET = 1;
    localparam int EV_STREAM_WRAP = 2;
    localparam int EV_W = 3;

    // ==========================================================
    // reset values; pin-dependent ones come in low / high pairs
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STATE_HI = 8'h01;
    localparam logic [7:0] RST_RANGE_HI = 8'h03;
    localparam logic [7:0] RST_RATE_HI = 8'hC0;
    localparam logic [7:0] RST_WAKE_IRQ = 8'h01;
    // revision as two bcd digits, 1.0 here; identity value is arbitrary
    localparam logic [7:0] REVISION_BCD = 8'h10;
    localparam logic [7:0] IDENTITY_CODE = 8'h5A;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [11:0] y;
        logic [11:0] z;
        logic [1:0] op_state;
        logic gate_error;
        logic [4:0] gate_count;
    } sensor_in_t;

    typedef struct packed {
        logic [7:0] range_selftest;
        logic [7:0] power_byteorder;
        logic [7:0] rate_decimation;
        logic [7:0] wake_irq_pin;
        logic [7:0] axis_skip;
        logic [11:0] wake_idle;
        logic [11:0] sleep_idle;
        logic [11:0] inact_count;
    } sensor_cfg_t;

endpackage

// *** src/accel_config_register_bank.sv ***
// register bank for the buffered y/z readout, identity, state and configuration
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps

module accel_config_register_bank
    import accel_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic boot_config_pin,
    input wire sensor_in_t sensor_in,
    output sensor_cfg_t sensor_cfg,
    output logic soft_reset_pulse,
    output logic irq
);

    // ==========================================================
    // boot pin synchroniser
    logic boot_meta;
    logic boot_sync;

    // pin is asynchronous; only boot_sync is read by logic
    always_ff @(posedge aclk) begin
        boot_meta <= boot_config_pin;
        boot_sync <= boot_meta;
    end

    // ==========================================================
    // write address / data capture
    logic aw_held;
    logic w_held;
    logic [IDX_W-1:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic do_write;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // address and data may arrive in either order; each is held until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= '0;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[ADDR_W-1:2];
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= '0;
            w_lane0 <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    // ==========================================================
    // decode of the write
    logic wr_cfg;
    logic wr_ro;

    always_comb begin
        wr_cfg = 1'b0;
        wr_ro = 1'b0;
        unique case (aw_idx)
            IDX_BUF_Y_LOW, IDX_BUF_Y_HIGH, IDX_BUF_Z_LOW, IDX_BUF_Z_HIGH,
            IDX_PRODUCT_REVISION, IDX_DEVICE_IDENTITY, IDX_OPERATING_STATE,
            IDX_STREAM_DATA: wr_ro = 1'b1;
            IDX_RANGE_SELFTEST, IDX_POWER_BYTEORDER, IDX_RATE_DECIMATION,
            IDX_WAKE_IRQ_PIN, IDX_AXIS_SKIP, IDX_WAKE_IDLE_LOW, IDX_WAKE_IDLE_HIGH,
            IDX_SLEEP_IDLE_LOW, IDX_SLEEP_IDLE_HIGH, IDX_INACT_LOW, IDX_INACT_HIGH,
            IDX_STREAM_PTR, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_cfg = 1'b1;
            default: ;
        endcase
    end

    // write response; read-only targets answer okay but change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_cfg || wr_ro) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_en;
    assign wr_en = do_write && w_lane0 && wr_cfg;

    // ==========================================================
    // configuration registers
    logic soft_pending;
    logic cfg_reset;

    // soft reset acts one cycle after the write so the writing cycle completes cleanly
    assign cfg_reset = !aresetn || soft_pending;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_pending <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_pending <= wr_en && aw_idx == IDX_RANGE_SELFTEST && w_byte[BIT_SOFT_RESET];
            soft_reset_pulse <= soft_pending;
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.range_selftest <= boot_sync ? RST_RANGE_HI : RST_ZERO;
        end else if (wr_en && aw_idx == IDX_RANGE_SELFTEST) begin
            // soft reset bit is self-clearing and never stored
            sensor_cfg.range_selftest <= w_byte & ~(8'h01 << BIT_SOFT_RESET);
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.power_byteorder <= RST_ZERO;
        end else if (wr_en && aw_idx == IDX_POWER_BYTEORDER) begin
            sensor_cfg.power_byteorder <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.rate_decimation <= boot_sync ? RST_RATE_HI : RST_ZERO;
        end else if (wr_en && aw_idx == IDX_RATE_DECIMATION) begin
            sensor_cfg.rate_decimation <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.wake_irq_pin <= RST_WAKE_IRQ;
        end else if (wr_en && aw_idx == IDX_WAKE_IRQ_PIN) begin
            sensor_cfg.wake_irq_pin <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.axis_skip <= RST_ZERO;
        end else if (wr_en && aw_idx == IDX_AXIS_SKIP) begin
            sensor_cfg.axis_skip <= w_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (cfg_reset) begin
            sensor_cfg.wake_idle <= '0;
            sensor_cfg.sleep_idle <= '0;
            sensor_cfg.inact_count <= '0;
        end else if (wr_en) begin
            unique case (aw_idx)
                IDX_WAKE_IDLE_LOW: sensor_cfg.wake_idle[7:0] <= w_byte;
                IDX_WAKE_IDLE_HIGH: sensor_cfg.wake_idle[11:8] <= w_byte[3:0];
                IDX_SLEEP_IDLE_LOW: sensor_cfg.sleep_idle[7:0] <= w_byte;
                IDX_SLEEP_IDLE_HIGH: sensor_cfg.sleep_idle[11:8] <= w_byte[3:0];
                IDX_INACT_LOW: sensor_cfg.inact_count[7:0] <= w_byte;
                IDX_INACT_HIGH: sensor_cfg.inact_count[11:8] <= w_byte[3:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // operating state register
    logic [7:0] op_state_reg;
    logic gate_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_state_reg <= boot_sync ? RST_STATE_HI : RST_ZERO;
            gate_prev <= 1'b0;
        end else begin
            op_state_reg <= {sensor_in.gate_error, sensor_in.gate_count, sensor_in.op_state};
            gate_prev <= sensor_in.gate_error;
        end
    end

    // ==========================================================
    // byte order and register read mux
    logic be;
    logic [7:0] y_low;
    logic [7:0] y_high;
    logic [7:0] z_low;
    logic [7:0] z_high;

    assign be = sensor_cfg.power_byteorder[BIT_BYTE_ORDER];
    assign y_low = be ? sensor_in.y[11:4] : sensor_in.y[7:0];
    assign y_high = be ? {4'h0, sensor_in.y[3:0]} : {4'h0, sensor_in.y[11:8]};
    assign z_low = be ? sensor_in.z[11:4] : sensor_in.z[7:0];
    assign z_high = be ? {4'h0, sensor_in.z[3:0]} : {4'h0, sensor_in.z[11:8]};

    logic [7:0] stream_ptr;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_mask;

    // returns {hit, byte} for one bank index
    function automatic logic [8:0] bank_read(input logic [7:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        unique case (idx)
            IDX_BUF_Y_LOW: r[7:0] = y_low;
            IDX_BUF_Y_HIGH: r[7:0] = y_high;
            IDX_BUF_Z_LOW: r[7:0] = z_low;
            IDX_BUF_Z_HIGH: r[7:0] = z_high;
            IDX_PRODUCT_REVISION: r[7:0] = REVISION_BCD;
            IDX_DEVICE_IDENTITY: r[7:0] = IDENTITY_CODE;
            IDX_OPERATING_STATE: r[7:0] = op_state_reg;
            IDX_RANGE_SELFTEST: r[7:0] = sensor_cfg.range_selftest;
            IDX_POWER_BYTEORDER: r[7:0] = sensor_cfg.power_byteorder;
            IDX_RATE_DECIMATION: r[7:0] = sensor_cfg.rate_decimation;
            IDX_WAKE_IRQ_PIN: r[7:0] = sensor_cfg.wake_irq_pin;
            IDX_AXIS_SKIP: r[7:0] = sensor_cfg.axis_skip;
            IDX_WAKE_IDLE_LOW: r[7:0] = sensor_cfg.wake_idle[7:0];
            IDX_WAKE_IDLE_HIGH: r[7:0] = {4'h0, sensor_cfg.wake_idle[11:8]};
            IDX_SLEEP_IDLE_LOW: r[7:0] = sensor_cfg.sleep_idle[7:0];
            IDX_SLEEP_IDLE_HIGH: r[7:0] = {4'h0, sensor_cfg.sleep_idle[11:8]};
            IDX_INACT_LOW: r[7:0] = sensor_cfg.inact_count[7:0];
            IDX_INACT_HIGH: r[7:0] = {4'h0, sensor_cfg.inact_count[11:8]};
            default: r[8] = 1'b0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // stream pointer stepping; returns {wrap, next index}
    logic y_skip;
    logic z_skip;
    logic [7:0] first_buf;

    assign y_skip = sensor_cfg.axis_skip[BIT_Y_SKIP];
    assign z_skip = sensor_cfg.axis_skip[BIT_Z_SKIP];
    assign first_buf = !y_skip ? IDX_BUF_Y_LOW : (!z_skip ? IDX_BUF_Z_LOW : IDX_PRODUCT_REVISION);

    function automatic logic [8:0] step_ptr(input logic [7:0] p);
        logic [8:0] n;
        logic [8:0] after_y;
        logic wrap_ok;
        wrap_ok = y_skip ? !z_skip : 1'b1;
        after_y = z_skip ? {wrap_ok, first_buf} : {1'b0, IDX_BUF_Z_LOW};
        n = {1'b0, p + 8'h01};
        unique case (p)
            IDX_BUF_Y_LOW: n = y_skip ? after_y : {1'b0, IDX_BUF_Y_HIGH};
            IDX_BUF_Y_HIGH: n = after_y;
            IDX_BUF_Z_LOW: n = z_skip ? {wrap_ok, first_buf} : {1'b0, IDX_BUF_Z_HIGH};
            IDX_BUF_Z_HIGH: n = {wrap_ok, first_buf};
            // end of range returns to first_buf: the first unskipped buffer register, or product revision when both axes are skipped
            IDX_INACT_HIGH: n = {1'b0, first_buf};
            default: ;
        endcase
        return n;
    endfunction

    // ==========================================================
    // read channel
    logic [8:0] rd_hit;
    logic [8:0] stream_rd;
    logic [8:0] stream_next;
    logic [IDX_W-1:0] ar_idx;
    logic rd_take;
    logic stream_read;
    logic [8:0] ptr_wr_hit;

    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign stream_read = rd_take && ar_idx == IDX_STREAM_DATA;

    // a process, not an assign, so config and sample changes seen inside the functions re-evaluate
    always_comb begin
        stream_rd = bank_read(stream_ptr);
        stream_next = step_ptr(stream_ptr);
        ptr_wr_hit = bank_read(w_byte);
    end

    always_comb begin
        rd_hit = bank_read(ar_idx);
        unique case (ar_idx)
            IDX_STREAM_PTR: rd_hit = {1'b1, stream_ptr};
            IDX_STREAM_DATA: rd_hit = {1'b1, stream_rd[7:0]};
            IDX_IRQ_STATUS: rd_hit = {1'b1, 5'h00, irq_status};
            IDX_IRQ_MASK: rd_hit = {1'b1, 5'h00, irq_mask};
            default: ;
        endcase
    end

    // one read outstanding; answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_hit[7:0]};
            s_axi_rresp <= rd_hit[8] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // stream pointer: written directly, advanced by each stream data read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stream_ptr <= IDX_BUF_Y_LOW;
        end else if (stream_read) begin
            stream_ptr <= stream_next[7:0];
        end else if (wr_en && aw_idx == IDX_STREAM_PTR) begin
            // out-of-range targets fall back to the first buffer register
            stream_ptr <= ptr_wr_hit[8] ? w_byte : IDX_BUF_Y_LOW;
        end
    end

    // ==========================================================
    // interrupt status, mask and output
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] clear_bits;

    always_comb begin
        events = '0;
        events[EV_GATE_ERROR] = sensor_in.gate_error && !gate_prev;
        events[EV_SOFT_RESET] = soft_pending;
        events[EV_STREAM_WRAP] = stream_read && stream_next[8];
    end

    assign clear_bits = (wr_en && aw_idx == IDX_IRQ_STATUS) ? w_byte[EV_W-1:0] : '0;

    // a new event in the clearing cycle survives: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~clear_bits) | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (wr_en && aw_idx == IDX_IRQ_MASK) begin
            irq_mask <= w_byte[EV_W-1:0];
        end
    end

    // registered output costs one cycle of latency after the status bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // the host must keep inact_count low byte at one or more; not enforced here

endmodule

// *** tb/accel_cfg_checker.sv ***
// assertions on the ports of the configuration register bank
`timescale 1ns/100ps
module accel_cfg_checker
    import accel_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic boot_config_pin,
    input wire sensor_in_t sensor_in,
    input wire sensor_cfg_t sensor_cfg,
    input wire logic soft_reset_pulse
);
    // ==========================================================
    // take events on the register bus
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire bo = sensor_cfg.power_byteorder[BIT_BYTE_ORDER];
    sequence rd_at(logic [7:0] i);
        s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == i;
    endsequence
    sequence wr_at(logic [7:0] i);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[9:2] == i;
    endsequence
    // ==========================================================
    // read data, sampled from what stood at the take edge
    a_y_low_order: assert property (rd_at(IDX_BUF_Y_LOW) |=> s_axi_rvalid &&
        s_axi_rdata[7:0] == ($past(bo) ? $past(sensor_in.y[11:4]) : $past(sensor_in.y[7:0])))
        else $error("y low byte wrong");
    a_z_high_order: assert property (rd_at(IDX_BUF_Z_HIGH) |=>
        s_axi_rdata[7:0] == {4'h0, ($past(bo) ? $past(sensor_in.z[3:0]) : $past(sensor_in.z[11:8]))})
        else $error("z high byte wrong");
    a_rev_bcd: assert property (rd_at(IDX_PRODUCT_REVISION) |=> s_axi_rdata[7:4] != 4'h0 &&
        s_axi_rdata[7:4] < 4'hA && s_axi_rdata[3:0] < 4'hA) else $error("revision not bcd");
    a_ident_fixed: assert property (rd_at(IDX_DEVICE_IDENTITY) |=>
        s_axi_rdata == {24'h0, IDENTITY_CODE}) else $error("identity changed");
    // reset values, pin already synchronised since reset lasts four edges
    a_irqcfg_reset: assert property ($rose(aresetn) |->
        sensor_cfg.wake_irq_pin == 8'h01) else $error("fourth config reset wrong");
    a_pin_reset: assert property ($rose(aresetn) |->
        sensor_cfg.range_selftest == (boot_config_pin ? 8'h03 : 8'h00) &&
        sensor_cfg.rate_decimation == (boot_config_pin ? 8'hC0 : 8'h00)) else $error("pin reset");
    // write commits on the edge that raises the response, so three edges always suffice
    a_wake_idle_wr: assert property (wr_at(IDX_WAKE_IDLE_LOW) |-> ##3
        sensor_cfg.wake_idle[7:0] == $past(s_axi_wdata[7:0], 3)) else $error("wake idle lost");
    a_soft_reset_pulse: assert property (wr_at(IDX_RANGE_SELFTEST) ##0
        s_axi_wdata[BIT_SOFT_RESET] |-> ##[1:5] soft_reset_pulse) else $error("no reset pulse");
endmodule

bind accel_config_register_bank accel_cfg_checker accel_cfg_checker_i (.*);

// *** tb/axi_host.sv ***
// bus master model standing in for the host controller
`timescale 1ns/100ps
module axi_host (
    input wire logic aclk,
    output logic [9:0] s_axi_awaddr, s_axi_araddr,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
    input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    // idle bus from time zero
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    end
    // a stuck handshake ends the run as a failure
    task automatic hung();
        tb.bad_count++;
        tb.complete_run();
    endtask
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 60);
        if (n >= 60) hung();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // the trailing edge keeps back-to-back calls from rewriting a strobe at once
    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 60);
        if (n >= 60) hung();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module tb;
    import accel_cfg_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic boot_config_pin = 1'b1;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, e;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic soft_reset_pulse, irq;
    sensor_in_t sensor_in = '0;
    sensor_cfg_t sensor_cfg;
    int bad_count = 0;
    int checked = 0;
    logic [7:0] order_exp [8] = '{8'hAB, 8'h0C, 8'h12, 8'h03, 8'hBC, 8'h0A, 8'h23, 8'h01};
    // 200 MHz clock
    always #2.5 aclk = ~aclk;
    accel_config_register_bank accel_config_register_bank_i (.*);
    axi_host axi_host_i (.*);
    // ==========================================================
    // comparison and access helpers
    task automatic chk_data(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
        chk_data({30'h0, g}, {30'h0, x});
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] x);
        axi_host_i.rd(i, d, r);
        chk_data(d, {24'h0, x});
        chk_resp(r, RESP_OKAY);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] x);
        axi_host_i.wr(i, x, r);
    endtask
    task automatic stream(input logic [7:0] skip, input logic [7:0] p, input logic [7:0] x [5]);
        wr(IDX_AXIS_SKIP, skip);
        wr(IDX_STREAM_PTR, p);
        for (int j = 0; j < 5; j++) begin
            rchk(IDX_STREAM_DATA, x[j]);
        end
    endtask
    // pin moves with reset asserted so the synchroniser settles inside it
    task automatic do_reset(input logic pin);
        aresetn <= 1'b0;
        boot_config_pin <= pin;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        do_reset(1'b1);
        rchk(IDX_RANGE_SELFTEST, 8'h03);
        rchk(IDX_RATE_DECIMATION, 8'hC0);
        do_reset(1'b0);
        rchk(IDX_RANGE_SELFTEST, 8'h00);
        rchk(IDX_WAKE_IRQ_PIN, 8'h01);
        axi_host_i.rd(IDX_PRODUCT_REVISION, e, r);
        wr(IDX_PRODUCT_REVISION, ~e[7:0]);
        rchk(IDX_PRODUCT_REVISION, e[7:0]);
        wr(IDX_DEVICE_IDENTITY, 8'h00);
        rchk(IDX_DEVICE_IDENTITY, IDENTITY_CODE);
        sensor_in <= '{y: 12'hABC, z: 12'h123, op_state: 2'h2, gate_error: 1'b1, gate_count: 5'h15};
        wr(IDX_OPERATING_STATE, 8'h00);
        rchk(IDX_OPERATING_STATE, 8'hD6);
        for (int i = 8'h15; i < 8'h20; i++) begin
            wr(8'(i), 8'(i - 8'h10));
            rchk(8'(i), 8'(i - 8'h10));
        end
        chk_data({8'h0, sensor_cfg.wake_idle, sensor_cfg.sleep_idle}, 32'h00B0AD0C);
        chk_data({20'h0, sensor_cfg.inact_count}, 32'h00000F0E);
        for (int k = 0; k < 8; k++) begin
            if (k == 4) wr(IDX_POWER_BYTEORDER, 8'h00);
            rchk(8'(8'h0E + k % 4), order_exp[k]);
        end
        wr(IDX_RANGE_SELFTEST, 8'h80);
        rchk(IDX_RANGE_SELFTEST, 8'h00);
        rchk(IDX_SLEEP_IDLE_HIGH, 8'h00);
        // gate error and soft reset events pending, raised only once unmasked
        chk_data({31'h0, irq}, 32'h0);
        wr(IDX_IRQ_MASK, 8'h02);
        chk_data({31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STATUS, 8'h02);
        chk_data({31'h0, irq}, 32'h0);
        axi_host_i.wr(8'h40, 8'h11, r);
        chk_resp(r, RESP_SLVERR);
        stream(8'h00, IDX_BUF_Y_LOW, '{8'hBC, 8'h0A, 8'h23, 8'h01, 8'hBC});
        stream(8'h40, IDX_BUF_Z_LOW, '{8'h23, 8'h01, 8'h23, 8'h01, 8'h23});
        stream(8'h20, IDX_BUF_Y_LOW, '{8'hBC, 8'h0A, 8'hBC, 8'h0A, 8'hBC});
        complete_run();
    end
endmodule
